// ### core/scpf_pkg.sv
// shared constants and types for the status clear and soft reset pulse logic
// assumes a single 125 MHz system clock and a synchronous active-low reset
package scpf_pkg;

  localparam int unsigned CLK_SYS_MHZ  = 125;
  localparam logic [2:0]  COUNT_ZERO   = 3'h0;
  localparam logic [2:0]  COUNT_ONE    = 3'h1;
  localparam logic [2:0]  PULSE_LAST   = 3'h4;

  localparam int unsigned LED_COUNT    = 4;
  localparam int unsigned LED_DIV_W    = 8;
  localparam logic [7:0]  LED_DIV_SLOW = 8'h0f;
  localparam logic [7:0]  LED_DIV_FAST = 8'h03;
  localparam logic [7:0]  LED_DIV_ZERO = 8'h00;
  localparam logic [7:0]  LED_DIV_ONE  = 8'h01;
  localparam logic [3:0]  LED_OFF      = 4'h0;
  localparam logic [3:0]  LED_FIRST    = 4'h1;

  typedef enum logic [9:0] {
    CS_IDLE                = 10'h001,
    CS_WAIT1               = 10'h002,
    CS_WAIT2               = 10'h004,
    CS_WAIT3               = 10'h008,
    CS_WAIT4               = 10'h010,
    CS_WAIT_FOR_REQUEST    = 10'h020,
    CS_WAIT_RESPONSE_START = 10'h040,
    CS_WAIT_RESPONSE_DONE  = 10'h080,
    CS_SET                 = 10'h100,
    CS_RELEASE             = 10'h200
  } scpf_clr_state_t;

  typedef enum logic [2:0] {
    PG_IDLE  = 3'h1,
    PG_SET   = 3'h2,
    PG_RESET = 3'h4
  } scpf_pulse_state_t;

  typedef struct packed {
    logic stop;
    logic rate_select;
    logic step_en_n;
  } scpf_led_ctrl_t;

  typedef struct packed {
    logic status_fsm;
    logic pulse_fsm;
  } scpf_err_t;

endpackage

// ### core/scpf_pulse_gen.sv
// soft reset pulse generator: one five-cycle pulse per rising request
// assumes request is synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module scpf_pulse_gen
  import scpf_pkg::*;
#(
  parameter logic [2:0] LAST_COUNT = PULSE_LAST
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pulse_request,
  input  wire logic err_clear,
  output var  logic pulse_out,
  output var  logic illegal_state_flag
);

  scpf_pulse_state_t state;
  scpf_pulse_state_t next_state;
  logic [2:0]        count;
  logic              illegal_hit;

  // next state decode
  always_comb begin
    next_state  = state;
    illegal_hit = 1'b0;
    case (state)
      PG_IDLE: begin
        if (pulse_request) begin
          next_state = PG_SET; // see [R12]
        end
      end
      PG_SET: begin
        if (count == LAST_COUNT) begin
          next_state = PG_RESET; // see [R13]
        end
      end
      PG_RESET: begin
        if (!pulse_request) begin
          next_state = PG_IDLE; // see [R14]
        end
      end
      default: begin
        next_state  = PG_IDLE;
        illegal_hit = 1'b1; // see [R15]
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= PG_IDLE; // see [R21]
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= COUNT_ZERO;
    end else if (state == PG_SET) begin
      count <= count + COUNT_ONE; // see [R13]
    end else begin
      count <= COUNT_ZERO;
    end
  end

  // output high only while in set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (next_state == PG_SET); // see [R12]
    end
  end

  // sticky; a new hit wins over a clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      illegal_state_flag <= 1'b0; // see [R21]
    end else if (illegal_hit) begin
      illegal_state_flag <= 1'b1; // see [R15]
    end else if (err_clear) begin
      illegal_state_flag <= 1'b0;
    end
  end

  a_pulse_width: assert property ( // see [R12]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(pulse_out) |-> pulse_out[*5] ##1 !pulse_out)
    else $error("soft reset pulse not five cycles");

  a_pulse_single: assert property ( // see [R14]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == PG_RESET && pulse_request) |=> (state == PG_RESET && !pulse_out))
    else $error("held request gave a second pulse");

endmodule

`default_nettype wire

// ### core/scpf_top.sv
// status flag clear machine, soft reset pulse and led sweep driver
// assumes all inputs synchronous to clk_sys; wf_clk_en marks waveform rate
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] both state machines run from the 125 MHz system clock
// [R2] clear output is high exactly five cycles per status request
// [R3] reset holds idle; after release four one-cycle wait states follow
// [R4] third and fourth wait states assert the flag clear for startup
// [R5] then wait for the request, then go to wait for response start
// [R6] response in progress going low moves to wait for response done
// [R7] response in progress returning high enters set and asserts clear
// [R8] set lasts until counter reaches four, then release drops the clear
// [R9] from release, go back to wait for response start once request is 0
// [R10] clear machine sets a sticky flag on an undefined state
// [R11] partner holds response in progress low while a response is sent
// [R12] soft reset generator gives a five-cycle high pulse per request
// [R13] request enters set with output high; count of four moves to reset
// [R14] reset state drives low and waits for request low before idle
// [R15] pulse generator sets a sticky flag on an undefined state
// [R16] led driver runs at waveform rate and sweeps four leds
// [R17] partner drives stop from inverse waveform running bit
// [R18] rate select high gives slower sweep, low gives faster sweep
// [R19] partner pulses the low step enable when its down counter empties
// [R20] partner raises the status request on a request status command
// [R21] reset holds both machines idle, outputs low, sticky flags cleared
module scpf_top
  import scpf_pkg::*;
#(
  parameter logic [LED_DIV_W-1:0] DIV_SLOW = LED_DIV_SLOW,
  parameter logic [LED_DIV_W-1:0] DIV_FAST = LED_DIV_FAST
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           status_request_strobe,
  input  wire logic           response_in_progress_n,
  input  wire logic           soft_reset_request,
  input  wire logic           err_clear,
  input  wire logic           wf_clk_en,
  input  wire scpf_led_ctrl_t led_ctrl,
  output var  logic           status_clear_out,
  output var  logic           soft_reset_out,
  output var  scpf_err_t      illegal_state_flag,
  output var  logic [3:0]     led_out
);

  scpf_clr_state_t      state;
  scpf_clr_state_t      next_state;
  logic [2:0]           count;
  logic                 illegal_hit;
  logic                 next_clear;
  logic                 status_flag;
  logic                 pulse_flag;

  logic [LED_DIV_W-1:0] div_count;
  logic [LED_DIV_W-1:0] div_limit;
  logic                 led_step;
  logic                 sweep_down;

  // status flag clear machine

  // next state decode
  always_comb begin
    next_state  = state;
    illegal_hit = 1'b0;
    case (state)
      CS_IDLE: begin
        next_state = CS_WAIT1; // see [R3]
      end
      CS_WAIT1: begin
        next_state = CS_WAIT2; // see [R3]
      end
      CS_WAIT2: begin
        next_state = CS_WAIT3; // see [R3]
      end
      CS_WAIT3: begin
        next_state = CS_WAIT4; // see [R3]
      end
      CS_WAIT4: begin
        next_state = CS_WAIT_FOR_REQUEST;
      end
      CS_WAIT_FOR_REQUEST: begin
        if (status_request_strobe) begin
          next_state = CS_WAIT_RESPONSE_START; // see [R5]
        end
      end
      CS_WAIT_RESPONSE_START: begin
        if (!response_in_progress_n) begin
          next_state = CS_WAIT_RESPONSE_DONE; // see [R6] and [R11]
        end
      end
      CS_WAIT_RESPONSE_DONE: begin
        if (response_in_progress_n) begin
          next_state = CS_SET; // see [R7]
        end
      end
      CS_SET: begin
        if (count == PULSE_LAST) begin
          next_state = CS_RELEASE; // see [R8]
        end
      end
      CS_RELEASE: begin
        if (status_request_strobe == 1'b0) begin
          next_state = CS_WAIT_RESPONSE_START; // see [R9]
        end
      end
      default: begin
        next_state  = CS_IDLE;
        illegal_hit = 1'b1; // see [R10]
      end
    endcase
  end

  // state register on the system clock
  always_ff @(posedge clk_sys) begin // see [R1]
    if (!rst_n) begin
      state <= CS_IDLE; // see [R3] and [R21]
    end else begin
      state <= next_state;
    end
  end

  // cycles spent in set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= COUNT_ZERO;
    end else if (state == CS_SET) begin
      count <= count + COUNT_ONE; // see [R8]
    end else begin
      count <= COUNT_ZERO;
    end
  end

  // clear asserted in the third and fourth startup waits and in set
  always_comb begin
    next_clear = (next_state == CS_WAIT3) || // see [R4]
                 (next_state == CS_WAIT4) ||
                 (next_state == CS_SET); // see [R2] and [R7]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_clear_out <= 1'b0; // see [R21]
    end else begin
      status_clear_out <= next_clear;
    end
  end

  // sticky undefined state flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_flag <= 1'b0; // see [R21]
    end else if (illegal_hit) begin
      status_flag <= 1'b1; // see [R10]
    end
  end

  // soft reset pulse generator

  scpf_pulse_gen #(
    .LAST_COUNT (PULSE_LAST)
  ) scpf_pulse_gen_i (
    .clk_sys            (clk_sys), // see [R1]
    .rst_n              (rst_n),
    .pulse_request      (soft_reset_request),
    .err_clear          (err_clear),
    .pulse_out          (soft_reset_out),
    .illegal_state_flag (pulse_flag)
  );

  always_comb begin
    illegal_state_flag.status_fsm = status_flag;
    illegal_state_flag.pulse_fsm  = pulse_flag;
  end

  // led sweep driver, stepped at waveform rate

  // divide ratio from rate select
  always_comb begin
    if (led_ctrl.rate_select) begin
      div_limit = DIV_SLOW; // see [R18]
    end else begin
      div_limit = DIV_FAST; // see [R18]
    end
  end

  // divider advances on waveform enable with step enable low
  always_ff @(posedge clk_sys) begin
    if (!rst_n || led_ctrl.stop) begin
      div_count <= LED_DIV_ZERO;
    end else if (wf_clk_en && !led_ctrl.step_en_n) begin // see [R16] and [R19]
      if (div_count >= div_limit) begin
        div_count <= LED_DIV_ZERO;
      end else begin
        div_count <= div_count + LED_DIV_ONE;
      end
    end
  end

  always_comb begin
    led_step = wf_clk_en && !led_ctrl.step_en_n && (div_count >= div_limit);
  end

  // sweep direction flips at either end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || led_ctrl.stop) begin
      sweep_down <= 1'b0;
    end else if (led_step) begin
      if (!sweep_down && led_out[LED_COUNT-1]) begin
        sweep_down <= 1'b1;
      end else if (sweep_down && led_out[0]) begin
        sweep_down <= 1'b0;
      end
    end
  end

  // one lit led walks back and forth
  always_ff @(posedge clk_sys) begin
    if (!rst_n || led_ctrl.stop) begin
      led_out <= LED_OFF; // see [R17]
    end else if (led_out == LED_OFF) begin
      led_out <= LED_FIRST;
    end else if (led_step) begin // see [R16]
      if (!sweep_down && led_out[LED_COUNT-1]) begin
        led_out <= led_out >> 1;
      end else if (sweep_down && led_out[0]) begin
        led_out <= led_out << 1;
      end else if (sweep_down) begin
        led_out <= led_out >> 1;
      end else begin
        led_out <= led_out << 1;
      end
    end
  end

  // checks

  a_clear_pulse_width: assert property ( // see [R2]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_SET && $past(state) != CS_SET) |->
      status_clear_out[*5] ##1 !status_clear_out)
    else $error("status clear pulse not five cycles");

  a_startup_walk: assert property ( // see [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (state == CS_IDLE) ##1 (state == CS_WAIT1) ##1
      (state == CS_WAIT2) ##1 (state == CS_WAIT3) ##1 (state == CS_WAIT4) ##1
      (state == CS_WAIT_FOR_REQUEST))
    else $error("startup wait states out of order");

  a_startup_clear: assert property ( // see [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_WAIT2) |-> !status_clear_out ##1 status_clear_out ##1
      status_clear_out ##1 !status_clear_out)
    else $error("startup flag clear not in third and fourth waits");

  a_request_taken: assert property ( // see [R5]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_WAIT_FOR_REQUEST && status_request_strobe) |=>
      (state == CS_WAIT_RESPONSE_START))
    else $error("request not taken from wait for request");

  a_response_start: assert property ( // see [R6]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_WAIT_RESPONSE_START && !response_in_progress_n) |=>
      (state == CS_WAIT_RESPONSE_DONE) && !status_clear_out)
    else $error("response start not seen");

  a_response_done: assert property ( // see [R7]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_WAIT_RESPONSE_DONE && response_in_progress_n) |=>
      (state == CS_SET) && status_clear_out)
    else $error("set not entered after response");

  a_release_return: assert property ( // see [R9]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_RELEASE && !status_request_strobe) |=>
      (state == CS_WAIT_RESPONSE_START))
    else $error("release state did not return to wait for response start");

  a_release_low: assert property ( // see [R8]
    @(posedge clk_sys) disable iff (!rst_n)
    (state == CS_RELEASE) |-> !status_clear_out)
    else $error("status clear high in release");

  a_illegal_sticky: assert property ( // see [R10]
    @(posedge clk_sys) disable iff (!rst_n)
    status_flag |=> status_flag)
    else $error("illegal state flag dropped");

  a_led_stop_dark: assert property ( // see [R17]
    @(posedge clk_sys) disable iff (!rst_n)
    led_ctrl.stop |=> (led_out == LED_OFF))
    else $error("leds lit while stopped");

  a_led_one_hot: assert property ( // see [R16]
    @(posedge clk_sys) disable iff (!rst_n)
    (led_out != LED_OFF) |-> $onehot(led_out))
    else $error("more than one led lit");

endmodule

`default_nettype wire

// ### sim/scpf_partner.sv
// model of the command interpreter around the clear and led logic
// assumes clk_sys with active-low synchronous reset; bench pulses resp_go for one cycle
`timescale 1ns/1ps
`default_nettype none

module scpf_partner
  import scpf_pkg::*;
#(
  parameter logic [15:0] STEP_RELOAD = 16'hffff
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           status_cmd,
  input  wire logic           resp_go,
  input  wire logic [7:0]     resp_len,
  input  wire logic [3:0]     command_register,
  output var  logic           status_request_strobe,
  output var  logic           response_in_progress_n,
  output var  logic           wf_clk_en,
  output var  scpf_led_ctrl_t led_ctrl
);
  logic [7:0]  resp_left;
  logic [15:0] step_cnt;

  assign status_request_strobe  = status_cmd;
  assign response_in_progress_n = (resp_left == 8'h00);
  assign wf_clk_en              = rst_n;
  // stop and rate from inverted command bits, step when counter empties
  assign led_ctrl = '{stop: ~command_register[3],
                      rate_select: ~command_register[0],
                      step_en_n: (step_cnt != 16'h0000)};

  // response held low for the whole transmission
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_left <= 8'h00;
    end else if (resp_go) begin
      resp_left <= resp_len;
    end else if (resp_left != 8'h00) begin
      resp_left <= resp_left - 8'h01;
    end
  end

  // down counter at waveform rate
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      step_cnt <= STEP_RELOAD;
    end else if (wf_clk_en) begin
      step_cnt <= (step_cnt == 16'h0000) ? STEP_RELOAD : step_cnt - 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ### sim/scpf_top_tb.sv
// self-checking bench for the clear machine, pulse generator and led driver
// assumes scpf_top and scpf_partner; inputs driven at the falling edge
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); num_errors++; end end

module scpf_top_tb;
  import scpf_pkg::*;
  localparam logic [15:0] STEP = 16'h0001;
  logic           clk_sys, rst_n, status_cmd, resp_go, soft_reset_request, err_clear;
  logic           status_request_strobe, response_in_progress_n, wf_clk_en;
  logic           status_clear_out, soft_reset_out;
  logic [7:0]     resp_len;
  logic [3:0]     cmd_reg, led_out;
  scpf_led_ctrl_t led_ctrl;
  scpf_err_t      illegal_state_flag;
  int             num_errors, check_count, cycles;

  scpf_partner #(.STEP_RELOAD(STEP)) scpf_partner_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .status_cmd(status_cmd), .resp_go(resp_go), .resp_len(resp_len), .command_register(cmd_reg),
    .status_request_strobe(status_request_strobe), .response_in_progress_n(response_in_progress_n),
    .wf_clk_en(wf_clk_en), .led_ctrl(led_ctrl));

  scpf_top scpf_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .status_request_strobe(status_request_strobe),
    .response_in_progress_n(response_in_progress_n), .soft_reset_request(soft_reset_request),
    .err_clear(err_clear), .wf_clk_en(wf_clk_en), .led_ctrl(led_ctrl),
    .status_clear_out(status_clear_out), .soft_reset_out(soft_reset_out),
    .illegal_state_flag(illegal_state_flag), .led_out(led_out));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  function automatic logic pick(input bit sel);
    return sel ? soft_reset_out : status_clear_out;
  endfunction

  // waits for a pulse, then measures how long it stays high
  task automatic high_len(input bit sel, input int lim, output int w, output int len);
    w = 0;
    len = 0;
    while (pick(sel) !== 1'b1 && w < lim) begin tick(1); w++; end
    while (pick(sel) === 1'b1 && len < 20) begin tick(1); len++; end
  endtask

  task automatic send_resp();
    resp_go = 1'b1;
    tick(1);
    resp_go = 1'b0;
  endtask

  // reset, clear, pulse and flag outputs checked low while held, then startup clear pair
  task automatic t_startup();
    logic [9:0] v;
    int first;
    rst_n = 1'b0;
    tick(4);
    `CHK("clear_in_reset", 1'b0, status_clear_out)
    `CHK("pulse_in_reset", 1'b0, soft_reset_out)
    `CHK("flags_in_reset", 2'h0, illegal_state_flag)
    rst_n = 1'b1;
    first = 10;
    for (int k = 0; k < 10; k++) begin
      tick(1);
      v[k] = status_clear_out;
      if (v[k] === 1'b1 && first == 10) first = k;
    end
    `CHK("startup_first", 2, first)
    `CHK("startup_clear", 10'h003 << first, v)
  endtask

  task automatic t_status();
    int w, len;
    status_cmd = 1'b1;
    tick(2);
    send_resp();
    high_len(0, 12, w, len);
    `CHK("clear_after_resp", int'(resp_len) + 1, w)
    `CHK("clear_len", 5, len)
    send_resp();
    high_len(0, 14, w, len);
    `CHK("clear_req_held", 0, len)
    status_cmd = 1'b0;
    tick(2);
    for (int r = 0; r < 2; r++) begin
      send_resp();
      high_len(0, 12, w, len);
      `CHK("clear_len_again", 5, len)
    end
  endtask

  task automatic t_pulse();
    int w, len;
    soft_reset_request = 1'b1;
    high_len(1, 3, w, len);
    `CHK("pulse_len", 5, len)
    high_len(1, 10, w, len);
    `CHK("pulse_held_req", 0, len)
    soft_reset_request = 1'b0;
    tick(1);
    soft_reset_request = 1'b1;
    high_len(1, 3, w, len);
    `CHK("pulse_len_again", 5, len)
    soft_reset_request = 1'b0;
    err_clear = 1'b1;
    tick(1);
    err_clear = 1'b0;
    `CHK("flags_idle", 2'h0, illegal_state_flag)
  endtask

  // waits one step, then times three further steps
  task automatic led_steps(input int per, output logic [3:0] nxt);
    logic [3:0] prev;
    int n;
    prev = led_out;
    n = 0;
    while (led_out === prev && n < 4 * per) begin tick(1); n++; end
    nxt = led_out;
    repeat (3) begin
      prev = led_out;
      n = 0;
      while (led_out === prev && n < 4 * per) begin tick(1); n++; end
      `CHK("led_period", per, n)
      `CHK("led_onehot", 1, $countones(led_out))
    end
  endtask

  task automatic t_led();
    logic [3:0] nxt;
    int n;
    cmd_reg = 4'h1;
    tick(3);
    `CHK("led_stopped", 4'h0, led_out)
    cmd_reg = 4'h9;
    n = 0;
    while (led_out !== 4'h1 && n < 4) begin tick(1); n++; end
    `CHK("led_first", 4'h1, led_out)
    led_steps((int'(LED_DIV_FAST) + 1) * (int'(STEP) + 1), nxt);
    `CHK("led_second", 4'h2, nxt)
    cmd_reg = 4'h8;
    led_steps((int'(LED_DIV_SLOW) + 1) * (int'(STEP) + 1), nxt);
    cmd_reg = 4'h0;
    tick(2);
    `CHK("led_off", 4'h0, led_out)
  endtask

  initial begin
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    status_cmd = 1'b0;
    resp_go = 1'b0;
    resp_len = 8'h04;
    soft_reset_request = 1'b0;
    err_clear = 1'b0;
    cmd_reg = 4'h0;
    t_startup();
    t_status();
    t_pulse();
    t_led();
    soft_reset_request = 1'b1;
    tick(2);
    soft_reset_request = 1'b0;
    t_startup();
    end_of_test();
  end
endmodule

`default_nettype wire
